// ==== hw/mps_defines.svh ====
// Timing counts and reset values shared by both ends of the power link.
// Assumes a single 50 MHz clock on both ends.
`ifndef MPS_DEFINES_SVH
`define MPS_DEFINES_SVH

// Clock rate in kHz, used to turn times into cycle counts.
`define MPS_CLK_KHZ          50000
// Least power button low time in ms.
`define MPS_T1_BUTTON_MS     16
`define MPS_T1_BUTTON_CYC    (`MPS_T1_BUTTON_MS * `MPS_CLK_KHZ)
// Least delay from supply on to supply good in ms.
`define MPS_T4_GOOD_MS       100
`define MPS_T4_GOOD_CYC      (`MPS_T4_GOOD_MS * `MPS_CLK_KHZ)
// Least power-down warning time in ms.
`define MPS_T7_WARN_MS       1
`define MPS_T7_WARN_CYC      (`MPS_T7_WARN_MS * `MPS_CLK_KHZ)
// Carrier reset hold after boot or reset request, in us.
`define MPS_RST_HOLD_US      20
`define MPS_RST_HOLD_CYC     (`MPS_RST_HOLD_US * `MPS_CLK_KHZ / 1000)
// Width of the reset request pulse sent by the carrier, in cycles.
`define MPS_REQ_PULSE_CYC    `MPS_RST_HOLD_CYC
// Synchroniser reset value of the five carrier inputs on the module.
// Bit order: button, reset request, supply good, wake, battery low.
`define MPS_IN_RST           5'h1b
// Synchroniser reset value of the five module outputs on the carrier.
// Bit order: carrier reset, pending, ram, disk, soft off.
`define MPS_OUT_RST          5'h02
`define MPS_CNT_W            32

`endif

// ==== hw/mps_pkg.sv ====
// Types shared by both ends of the power link.
// Assumes mps_defines.svh for the counts.
package mps_pkg;

  // Module power state, from soft off up to running, then the warning and the ram and disk sleep states.
  typedef enum logic [2:0] {
    MPS_OFF, MPS_WAIT_GOOD, MPS_RESET, MPS_RUN, MPS_WARN, MPS_RAM, MPS_DISK
  } mps_state_type;

  // Sleep depth requested by the module's own software.
  typedef enum logic [1:0] {
    MPS_SLP_RAM, MPS_SLP_DISK, MPS_SLP_OFF
  } mps_sleep_type;

endpackage : mps_pkg

// ==== hw/mps_if.sv ====
// Interface carrying the power and reset pins between module and carrier.
// Assumes both ends run on one clock; the pins are plain levels.
`timescale 1ns/100ps
interface mps_if;
  logic power_button_n;
  logic reset_request_n;
  logic supply_good;
  logic general_wake_n;
  logic battery_low_n;
  logic carrier_reset_out_n;
  logic suspend_pending_n;
  logic suspend_to_ram_n;
  logic suspend_to_disk_n;
  logic soft_off_n;

  // Module end drives the reset and sleep-state pins.
  modport module_end (
    input  power_button_n, reset_request_n, supply_good,
    input  general_wake_n, battery_low_n,
    output carrier_reset_out_n, suspend_pending_n,
    output suspend_to_ram_n, suspend_to_disk_n, soft_off_n
  );

  // Carrier end drives the button, reset request, supply and event pins.
  modport carrier_end (
    output power_button_n, reset_request_n, supply_good,
    output general_wake_n, battery_low_n,
    input  carrier_reset_out_n, suspend_pending_n,
    input  suspend_to_ram_n, suspend_to_disk_n, soft_off_n
  );
endinterface : mps_if

// ==== hw/mps_module_end.sv ====
// Module end of the power link: sleep states, carrier reset and wake.
// Assumes the carrier pins arrive asynchronously and one 50 MHz clock.
`timescale 1ns/100ps
`include "mps_defines.svh"

module mps_module_end
  import mps_pkg::*;
#(
  parameter int unsigned WARN_CYC = `MPS_T7_WARN_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  mps_if.module_end          link,
  input  wire logic          sleep_valid,
  input  wire mps_sleep_type sleep_depth,
  output mps_state_type      power_state_q,
  output logic               reboot_event_q,
  output logic               wake_event_q,
  output logic               battery_low_q
);

  localparam int unsigned HOLD_CYC = `MPS_RST_HOLD_CYC;
  localparam int          NIN      = 5;
  // Reset levels of the synchronisers, one bit per carrier input.
  localparam logic [NIN-1:0] IN_RST = `MPS_IN_RST;

  // Input bit positions within the synchroniser vector.
  localparam int IN_BTN  = 0;
  localparam int IN_RREQ = 1;
  localparam int IN_GOOD = 2;
  localparam int IN_WAKE = 3;
  localparam int IN_BATT = 4;

  logic [NIN-1:0]           pin_raw;
  logic [NIN-1:0]           sync1_q;
  logic [NIN-1:0]           sync2_q;
  logic [NIN-1:0]           sync3_q;
  logic [NIN-1:0]           stable_q;
  logic [NIN-1:0]           prev_q;
  logic                     btn_fall;
  logic                     rreq_fall;
  logic                     good;
  logic                     wake_low;
  mps_state_type            state_q;
  mps_sleep_type            target_q;
  logic [`MPS_CNT_W-1:0]    cnt_q;
  logic                     cnt_done;

  assign pin_raw = {link.battery_low_n, link.general_wake_n,
                    link.supply_good, link.reset_request_n,
                    link.power_button_n};

  // Three-stage synchronisers; a level counts once stages two and three
  // agree, which also filters a single-cycle glitch on the pin.
  for (genvar i = 0; i < NIN; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        sync1_q[i]  <= IN_RST[i];
        sync2_q[i]  <= IN_RST[i];
        sync3_q[i]  <= IN_RST[i];
        stable_q[i] <= IN_RST[i];
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
        if (sync2_q[i] == sync3_q[i]) begin
          stable_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // Previous stable levels, kept for edge detection.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= `MPS_IN_RST;
    end else begin
      prev_q <= stable_q;
    end
  end

  // Both buttons act on their falling edge only.
  assign btn_fall  = prev_q[IN_BTN] & ~stable_q[IN_BTN];
  assign rreq_fall = prev_q[IN_RREQ] & ~stable_q[IN_RREQ];
  assign good      = stable_q[IN_GOOD];
  assign wake_low  = ~stable_q[IN_WAKE];
  assign cnt_done  = (cnt_q == '0);

  // Power state sequence; reset leaves the module in soft off.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q  <= MPS_OFF;
      target_q <= MPS_SLP_OFF;
    end else begin
      unique case (state_q)
        MPS_OFF: begin
          if (btn_fall) begin
            state_q <= MPS_WAIT_GOOD;
          end
        end
        MPS_WAIT_GOOD: begin
          // Boot is held off for as long as supply good stays low.
          if (good) begin
            state_q <= MPS_RESET;
          end
        end
        MPS_RESET: begin
          if (!good) begin
            state_q <= MPS_WAIT_GOOD;
          end else if (cnt_done) begin
            state_q <= MPS_RUN;
          end
        end
        MPS_RUN: begin
          if (!good) begin
            state_q <= MPS_WAIT_GOOD;
          end else if (rreq_fall) begin
            state_q <= MPS_RESET;
          end else if (sleep_valid) begin
            state_q  <= MPS_WARN;
            target_q <= sleep_depth;
          end
        end
        MPS_WARN: begin
          if (cnt_done) begin
            unique case (target_q)
              MPS_SLP_RAM:  state_q <= MPS_RAM;
              MPS_SLP_DISK: state_q <= MPS_DISK;
              default:      state_q <= MPS_OFF;
            endcase
          end
        end
        MPS_RAM, MPS_DISK: begin
          if (btn_fall || wake_low) begin
            state_q <= MPS_WAIT_GOOD;
          end
        end
      endcase
    end
  end

  // Down counter for the reset hold and the power-down warning.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (state_q == MPS_WAIT_GOOD ||
                 (state_q == MPS_RUN && rreq_fall)) begin
      cnt_q <= `MPS_CNT_W'(HOLD_CYC - 1);
    end else if (state_q == MPS_RUN && sleep_valid) begin
      cnt_q <= `MPS_CNT_W'(WARN_CYC - 1);
    end else if (!cnt_done) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Carrier reset and sleep-state pins, registered from the state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.carrier_reset_out_n <= 1'b0;
      link.suspend_pending_n   <= 1'b0;
      link.suspend_to_ram_n    <= 1'b0;
      link.suspend_to_disk_n   <= 1'b0;
      link.soft_off_n          <= 1'b0;
    end else begin
      // Carrier parts run only while the module is fully up.
      link.carrier_reset_out_n <= (state_q == MPS_RUN ||
                                   state_q == MPS_WARN);
      // Warning leads the sleep states by the warning time.
      link.suspend_pending_n   <= !(state_q == MPS_WARN ||
                                    state_q == MPS_RAM ||
                                    state_q == MPS_DISK ||
                                    state_q == MPS_OFF);
      // Deeper states also assert the shallower pins.
      link.suspend_to_ram_n    <= !(state_q == MPS_RAM ||
                                    state_q == MPS_DISK ||
                                    state_q == MPS_OFF);
      link.suspend_to_disk_n   <= !(state_q == MPS_DISK ||
                                    state_q == MPS_OFF);
      link.soft_off_n          <= !(state_q == MPS_OFF);
    end
  end

  // User-side state and event report.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_state_q  <= MPS_OFF;
      reboot_event_q <= 1'b0;
      wake_event_q   <= 1'b0;
      battery_low_q  <= 1'b0;
    end else begin
      power_state_q  <= state_q;
      reboot_event_q <= (state_q == MPS_RUN) && good && rreq_fall;
      wake_event_q   <= (state_q == MPS_RAM || state_q == MPS_DISK) &&
                        (btn_fall || wake_low);
      // Low battery is passed on as a level for software to act upon.
      battery_low_q  <= ~stable_q[IN_BATT];
    end
  end

endmodule : mps_module_end

// ==== hw/mps_carrier_end.sv ====
// Carrier end of the power link: button, reset, supply and event pins.
// Assumes the module pins arrive asynchronously and one 50 MHz clock.
`timescale 1ns/100ps
`include "mps_defines.svh"

module mps_carrier_end
  import mps_pkg::*;
#(
  parameter int unsigned BUTTON_CYC = `MPS_T1_BUTTON_CYC,
  parameter int unsigned GOOD_CYC   = `MPS_T4_GOOD_CYC
) (
  input  wire logic    clk,
  input  wire logic    rst_n,
  mps_if.carrier_end   link,
  input  wire logic    press_button,
  input  wire logic    press_reset,
  input  wire logic    recover,
  input  wire logic    config_done,
  input  wire logic    wake_req,
  input  wire logic    battery_low,
  output logic         supply_on_n_q,
  output logic [4:0]   module_pins_q
);

  localparam int unsigned REQ_CYC = `MPS_REQ_PULSE_CYC;
  // Reset levels of the synchronisers, one bit per module output.
  localparam logic [4:0]  OUT_RST = `MPS_OUT_RST;

  logic [4:0]            pin_raw;
  logic [4:0]            sync1_q;
  logic [4:0]            sync2_q;
  logic [4:0]            sync3_q;
  logic [`MPS_CNT_W-1:0] btn_cnt_q;
  logic [`MPS_CNT_W-1:0] req_cnt_q;
  logic [`MPS_CNT_W-1:0] good_cnt_q;

  assign pin_raw = {link.soft_off_n, link.suspend_to_disk_n,
                    link.suspend_to_ram_n, link.suspend_pending_n,
                    link.carrier_reset_out_n};

  // Three-stage synchronisers on the module outputs.
  for (genvar i = 0; i < 5; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        sync1_q[i]       <= OUT_RST[i];
        sync2_q[i]       <= OUT_RST[i];
        sync3_q[i]       <= OUT_RST[i];
        module_pins_q[i] <= OUT_RST[i];
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
        if (sync2_q[i] == sync3_q[i]) begin
          module_pins_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // Power button held low for the least press time.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      btn_cnt_q           <= '0;
      link.power_button_n <= 1'b1;
    end else begin
      if (press_button && btn_cnt_q == '0) begin
        btn_cnt_q <= `MPS_CNT_W'(BUTTON_CYC);
      end else if (btn_cnt_q != '0) begin
        btn_cnt_q <= btn_cnt_q - 1'b1;
      end
      link.power_button_n <= !(press_button || btn_cnt_q > 1);
    end
  end

  // Reset request sent as a low pulse; the module acts on its fall.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_cnt_q            <= '0;
      link.reset_request_n <= 1'b1;
    end else begin
      if (press_reset && req_cnt_q == '0) begin
        req_cnt_q <= `MPS_CNT_W'(REQ_CYC);
      end else if (req_cnt_q != '0) begin
        req_cnt_q <= req_cnt_q - 1'b1;
      end
      link.reset_request_n <= !(press_reset || req_cnt_q > 1);
    end
  end

  // Main supply follows the ram sleep pin; supply good rises after the
  // delay, only with configuration done, and drops on a recovery.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supply_on_n_q    <= 1'b1;
      good_cnt_q       <= '0;
      link.supply_good <= 1'b0;
    end else begin
      supply_on_n_q <= ~module_pins_q[2];
      if (supply_on_n_q || recover) begin
        good_cnt_q <= `MPS_CNT_W'(GOOD_CYC);
      end else if (good_cnt_q != '0) begin
        good_cnt_q <= good_cnt_q - 1'b1;
      end
      link.supply_good <= !supply_on_n_q && !recover &&
                          good_cnt_q == '0 && config_done;
    end
  end

  // Wake and battery events as active-low levels.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.general_wake_n <= 1'b1;
      link.battery_low_n  <= 1'b1;
    end else begin
      link.general_wake_n <= ~wake_req;
      link.battery_low_n  <= ~battery_low;
    end
  end

endmodule : mps_carrier_end

// ==== sim/mps_assertions.sv ====
// Checker for the power link between the module end and the carrier end.
// Assumes one clock and a synchronous active-low reset on both ends.
`timescale 1ns/100ps
`include "mps_defines.svh"
module mps_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_button_n,
  input wire logic reset_request_n,
  input wire logic supply_good,
  input wire logic general_wake_n,
  input wire logic carrier_reset_out_n,
  input wire logic suspend_pending_n,
  input wire logic suspend_to_ram_n,
  input wire logic suspend_to_disk_n,
  input wire logic soft_off_n
);
  int unsigned low_cnt_q;

  // Counts how long the carrier reset pin has been held low.
  always_ff @(posedge clk) begin
    if (!rst_n || carrier_reset_out_n) low_cnt_q <= 0;
    else low_cnt_q <= low_cnt_q + 1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // The module is running when reset is released and no sleep is pending.
  sequence run_s;
    carrier_reset_out_n && suspend_pending_n;
  endsequence
  sequence req_fall_s;
    $fell(reset_request_n) ##0 run_s;
  endsequence
  sequence good_loss_s;
    $fell(supply_good) ##0 run_s;
  endsequence

  off_cascade_a:
    assert property (!soft_off_n |-> !suspend_to_disk_n)
    else $error("Soft off pin low while disk pin high.");
  disk_cascade_a:
    assert property (!suspend_to_disk_n |-> !suspend_to_ram_n)
    else $error("Disk pin low while ram pin high.");
  sleep_reset_a:
    assert property (!suspend_to_ram_n |-> !carrier_reset_out_n)
    else $error("Carrier reset released during sleep.");
  warn_first_a:
    assert property ($fell(suspend_to_ram_n) |-> !$past(suspend_pending_n, 4))
    else $error("Ram pin fell without an early pending warning.");
  warn_hold_a:
    assert property ($fell(suspend_pending_n) && carrier_reset_out_n
                     |-> carrier_reset_out_n [*8])
    else $error("Carrier reset dropped during the warning time.");
  reset_hold_a:
    assert property ($rose(carrier_reset_out_n)
                     |-> low_cnt_q >= `MPS_RST_HOLD_CYC)
    else $error("Carrier reset released too early.");
  reboot_reset_a:
    assert property (req_fall_s |-> ##[1:10] !carrier_reset_out_n)
    else $error("Reset request did not reset the carrier.");
  good_loss_a:
    assert property (good_loss_s |-> ##[1:10] !carrier_reset_out_n)
    else $error("Loss of supply good did not reset the carrier.");
  button_wake_a:
    assert property ($fell(power_button_n) && !soft_off_n
                     |-> ##[1:10] soft_off_n)
    else $error("Button press did not leave soft off.");
  wake_resume_a:
    assert property ($fell(general_wake_n) && !suspend_to_ram_n && soft_off_n
                     |-> ##[1:10] suspend_to_ram_n)
    else $error("Wake input did not resume from sleep.");
endmodule : mps_assertions

// ==== sim/test_module_power_state_signals.sv ====
// Testbench joining the module end and the carrier end over the link.
// Assumes short counts set by parameters and one 50 MHz clock.
`timescale 1ns/100ps
module test_module_power_state_signals;
  import mps_pkg::*;
  typedef struct packed {
    logic [1:0]    act;
    mps_sleep_type depth;
    mps_state_type state;
    logic [4:0]    pins;
  } mps_row_type;
  logic          clk, rst_n, sleep_valid, press_button, press_reset;
  logic          recover, config_done, wake_req, battery_low;
  logic          battery_low_q, supply_on_n_q;
  logic          reboot_event_q, wake_event_q;
  int            reboot_seen, wake_seen;
  logic [4:0]    module_pins_q;
  mps_sleep_type sleep_depth;
  mps_state_type power_state_q;
  int            bad_count, checks_done;
  mps_row_type   rows [8];
  mps_if         link ();

  mps_module_end #(.WARN_CYC(10)) u_mps_module_end (
    .clk(clk), .rst_n(rst_n), .link(link), .sleep_valid(sleep_valid),
    .sleep_depth(sleep_depth), .power_state_q(power_state_q),
    .reboot_event_q(reboot_event_q), .wake_event_q(wake_event_q),
    .battery_low_q(battery_low_q));
  mps_carrier_end #(.BUTTON_CYC(20), .GOOD_CYC(30)) u_mps_carrier_end (
    .clk(clk), .rst_n(rst_n), .link(link), .press_button(press_button),
    .press_reset(press_reset), .recover(recover),
    .config_done(config_done), .wake_req(wake_req),
    .battery_low(battery_low), .supply_on_n_q(supply_on_n_q),
    .module_pins_q(module_pins_q));
  mps_assertions u_mps_assertions (
    .clk(clk), .rst_n(rst_n), .power_button_n(link.power_button_n),
    .reset_request_n(link.reset_request_n),
    .supply_good(link.supply_good), .general_wake_n(link.general_wake_n),
    .carrier_reset_out_n(link.carrier_reset_out_n),
    .suspend_pending_n(link.suspend_pending_n),
    .suspend_to_ram_n(link.suspend_to_ram_n),
    .suspend_to_disk_n(link.suspend_to_disk_n),
    .soft_off_n(link.soft_off_n));

  // Makes the 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check_state(input mps_state_type got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: state %h expected %h", $time, got, exp);
    end
  endtask : check_state

  task automatic check_bits(input logic [4:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: bits %h expected %h", $time, got, exp);
    end
  endtask : check_bits

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // Raises one request for four cycles: button, sleep, wake or reset.
  task automatic act_go(input logic [1:0] act);
    @(posedge clk);
    press_button <= (act == 2'h0);
    sleep_valid  <= (act == 2'h1);
    wake_req     <= (act == 2'h2);
    press_reset  <= (act == 2'h3);
    repeat (4) @(posedge clk);
    {press_button, sleep_valid, wake_req, press_reset} <= 4'h0;
  endtask : act_go

  task automatic wait_state(input mps_state_type exp);
    int n;
    n = 0;
    while (power_state_q !== exp && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_state

  // Counts the one-cycle event pulses reported to the module's software.
  always @(posedge clk) begin
    if (reboot_event_q === 1'b1) reboot_seen++;
    if (wake_event_q === 1'b1) wake_seen++;
  end

  // Cuts a hung run short after far more cycles than the tests need.
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  // Runs the table of power transitions, then the awkward cases.
  initial begin
    rst_n = 1'b0;
    {sleep_valid, press_button, press_reset, recover, wake_req} = 5'h00;
    battery_low = 1'b0;
    config_done = 1'b1;
    sleep_depth = MPS_SLP_RAM;
    rows = '{'{2'h0, MPS_SLP_RAM, MPS_RUN, 5'h1f},
             '{2'h1, MPS_SLP_RAM, MPS_RAM, 5'h18},
             '{2'h2, MPS_SLP_RAM, MPS_RUN, 5'h1f},
             '{2'h1, MPS_SLP_DISK, MPS_DISK, 5'h10},
             '{2'h0, MPS_SLP_RAM, MPS_RUN, 5'h1f},
             '{2'h3, MPS_SLP_RAM, MPS_RUN, 5'h1f},
             '{2'h1, MPS_SLP_OFF, MPS_OFF, 5'h00},
             '{2'h0, MPS_SLP_RAM, MPS_RUN, 5'h1f}};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      sleep_depth <= rows[i].depth;
      act_go(rows[i].act);
      repeat (20) @(posedge clk);
      wait_state(rows[i].state);
      repeat (8) @(posedge clk);
      check_state(power_state_q, rows[i].state);
      check_bits(module_pins_q, rows[i].pins);
      check_bits({4'h0, supply_on_n_q}, {4'h0, ~rows[i].pins[2]});
    end
    act_go(2'h0);
    repeat (60) @(posedge clk);
    check_state(power_state_q, MPS_RUN);
    recover <= 1'b1;
    repeat (20) @(posedge clk);
    check_state(power_state_q, MPS_WAIT_GOOD);
    check_bits({4'h0, link.carrier_reset_out_n}, 5'h00);
    act_go(2'h1);
    config_done <= 1'b0;
    recover <= 1'b0;
    repeat (100) @(posedge clk);
    check_state(power_state_q, MPS_WAIT_GOOD);
    check_bits({4'h0, link.supply_good}, 5'h00);
    config_done <= 1'b1;
    repeat (20) @(posedge clk);
    wait_state(MPS_RUN);
    repeat (40) @(posedge clk);
    check_state(power_state_q, MPS_RUN);
    battery_low <= 1'b1;
    repeat (8) @(posedge clk);
    check_bits({4'h0, battery_low_q}, 5'h01);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    check_state(power_state_q, MPS_OFF);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check_bits({link.soft_off_n, link.suspend_to_disk_n,
                link.suspend_to_ram_n, link.suspend_pending_n,
                link.carrier_reset_out_n}, 5'h00);
    check_bits(5'(reboot_seen), 5'h01);
    check_bits(5'(wake_seen), 5'h02);
    stop_test();
  end
endmodule : test_module_power_state_signals
